// ### verilog/godr_port.sv
// godr_port: 32-pin general-purpose port with hardware and emulated open-drain drive
// assumes software strobes arrive on mclk_in; pad wire resolution happens outside
`timescale 1ns/1ns
module godr_port
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // protection unlock / relock strobes
    input wire logic protected_write_enable_in,
    input wire logic protected_write_disable_in,
    // protected configuration writes, one strobe and word each
    input wire logic pullup_disable_wr_in,
    input wire logic [31:0] pullup_disable_wdata_in,
    input wire logic open_drain_select_wr_in,
    input wire logic [31:0] open_drain_select_wdata_in,
    input wire logic pin_direction_wr_in,
    input wire logic [31:0] pin_direction_wdata_in,
    // output value access, not protected
    input wire logic pin_output_value_wr_in,
    input wire logic [31:0] pin_output_value_wdata_in,
    input wire logic pin_value_clear_wr_in,
    input wire logic [31:0] pin_value_clear_wdata_in,
    // pads
    input wire logic [31:0] pad_in,
    output logic [31:0] pad_out,
    output logic [31:0] pad_oe_out,
    output logic [31:0] pad_pullup_en_out,
    // readback
    output logic [31:0] pin_level_out,
    output logic [31:0] pin_output_value_out,
    output logic [31:0] pin_direction_out,
    output logic [31:0] open_drain_select_out,
    output logic [31:0] pullup_disable_out,
    output logic protected_write_open_out
);
    // ********************************************************
    // protection state
    // ********************************************************
    godr_pkg::godr_lock_t lock_state;
    godr_pkg::godr_lock_t next_lock_state;

    // disable wins when both strobes coincide, the safer outcome
    always_comb
    begin
        case (lock_state)
            godr_pkg::GODR_LOCKED:
                next_lock_state = (protected_write_enable_in && !protected_write_disable_in)
                    ? godr_pkg::GODR_OPEN : godr_pkg::GODR_LOCKED;
            godr_pkg::GODR_OPEN:
                next_lock_state = protected_write_disable_in
                    ? godr_pkg::GODR_LOCKED : godr_pkg::GODR_OPEN;
            default:
                next_lock_state = godr_pkg::GODR_LOCKED;
        endcase
    end

    wire prot_open = (lock_state == godr_pkg::GODR_OPEN);

    // ********************************************************
    // word helpers
    // ********************************************************
    // a strobe replaces the whole word; single pins need read-modify-write by software
    function automatic logic [31:0] godr_take
    (
        input logic strobe,
        input logic [31:0] wdata,
        input logic [31:0] current
    );
        godr_take = strobe ? wdata : current;
    endfunction

    // an open-drain pin never drives a one, so its data bit is masked off
    function automatic logic [31:0] godr_pad_drive
    (
        input logic [31:0] value,
        input logic [31:0] odr_sel
    );
        godr_pad_drive = value & ~odr_sel;
    endfunction

    // push-pull: driver on with direction; open-drain: on only while driving low
    function automatic logic [31:0] godr_pad_enable
    (
        input logic [31:0] dir,
        input logic [31:0] value,
        input logic [31:0] odr_sel
    );
        godr_pad_enable = dir & ~(odr_sel & value);
    endfunction

    // ********************************************************
    // write qualification
    // ********************************************************
    wire pud_we = pullup_disable_wr_in && prot_open;
    wire odr_we = open_drain_select_wr_in && prot_open;
    wire dir_we = pin_direction_wr_in && prot_open;

    // ********************************************************
    // next values
    // ********************************************************
    logic [31:0] clear_mask;
    logic [31:0] next_output_value;
    logic [31:0] next_dir;
    logic [31:0] next_odr;
    logic [31:0] next_pud;
    logic [31:0] next_pad_out;
    logic [31:0] next_pad_oe;

    // the clear word is not protected, so emulation never needs an unlock
    assign clear_mask = pin_value_clear_wr_in ? pin_value_clear_wdata_in : 32'h0000_0000;
    // a clear in the same cycle as a data write wins for the cleared bits
    assign next_output_value =
        godr_take(pin_output_value_wr_in, pin_output_value_wdata_in, pin_output_value_out)
        & ~clear_mask;
    assign next_dir = godr_take(dir_we, pin_direction_wdata_in, pin_direction_out);
    assign next_odr = godr_take(odr_we, open_drain_select_wdata_in, open_drain_select_out);
    assign next_pud = godr_take(pud_we, pullup_disable_wdata_in, pullup_disable_out);

    // pads follow next values so they change with the configuration, with no extra lag
    assign next_pad_out = godr_pad_drive(next_output_value, next_odr);
    assign next_pad_oe = godr_pad_enable(next_dir, next_output_value, next_odr);

    // ********************************************************
    // protection register
    // ********************************************************
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            lock_state <= godr_pkg::GODR_LOCKED;
            protected_write_open_out <= godr_pkg::RST_PROTECT_OPEN;
        end
        else
        begin
            lock_state <= next_lock_state;
            protected_write_open_out <= (next_lock_state == godr_pkg::GODR_OPEN);
        end
    end

    // ********************************************************
    // configuration and data registers
    // ********************************************************
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            pin_output_value_out <= godr_pkg::RST_OUTPUT_VALUE;
        end
        else
        begin
            pin_output_value_out <= next_output_value;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            pin_direction_out <= godr_pkg::RST_DIRECTION;
        end
        else
        begin
            pin_direction_out <= next_dir;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            open_drain_select_out <= godr_pkg::RST_OPEN_DRAIN;
        end
        else
        begin
            open_drain_select_out <= next_odr;
        end
    end

    // the pull-up enable has its own flop so the pad sees no gate behind the register
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            pullup_disable_out <= godr_pkg::RST_PULLUP_DISABLE;
            pad_pullup_en_out <= ~godr_pkg::RST_PULLUP_DISABLE;
        end
        else
        begin
            pullup_disable_out <= next_pud;
            pad_pullup_en_out <= ~next_pud;
        end
    end

    // ********************************************************
    // pad registers
    // ********************************************************
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            pad_out <= godr_pad_drive(godr_pkg::RST_OUTPUT_VALUE, godr_pkg::RST_OPEN_DRAIN);
            pad_oe_out <= godr_pad_enable(godr_pkg::RST_DIRECTION,
                godr_pkg::RST_OUTPUT_VALUE, godr_pkg::RST_OPEN_DRAIN);
        end
        else
        begin
            pad_out <= next_pad_out;
            pad_oe_out <= next_pad_oe;
        end
    end

    // ********************************************************
    // input path
    // ********************************************************
    godr_pin_sync u_sync
    (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .pad_in(pad_in),
        .level_out(pin_level_out)
    );
endmodule // godr_port

// ### verilog/godr_pkg.sv
// godr_pkg: constants shared by the open-drain gpio port and its pin synchroniser
// assumes a single 250 mhz clock domain and a synchronous active-low reset
package godr_pkg;

    // ********************************************************
    // widths
    // ********************************************************
    localparam int unsigned PIN_COUNT = 32;
    localparam int unsigned SYNC_STAGES = 3;

    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [31:0] RST_OUTPUT_VALUE = 32'h0000_0000;
    localparam logic [31:0] RST_DIRECTION = 32'h0000_0000;
    localparam logic [31:0] RST_OPEN_DRAIN = 32'h0000_0000;
    localparam logic [31:0] RST_PULLUP_DISABLE = 32'h0000_0000;
    localparam logic RST_PROTECT_OPEN = 1'b0;

    // ********************************************************
    // write unlock states
    // ********************************************************
    typedef enum logic [0:0] {
        GODR_LOCKED = 1'b0,
        GODR_OPEN = 1'b1
    } godr_lock_t;

endpackage

// ### verilog/godr_pin_sync.sv
// godr_pin_sync: three-stage synchroniser for the pad input levels
// assumes pad levels are asynchronous to mclk_in; output changes once stages two and three agree
`timescale 1ns/1ns
module godr_pin_sync
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [godr_pkg::PIN_COUNT-1:0] pad_in,
    output logic [godr_pkg::PIN_COUNT-1:0] level_out
);
    logic [godr_pkg::PIN_COUNT-1:0] meta;
    logic [godr_pkg::PIN_COUNT-1:0] stage2;
    logic [godr_pkg::PIN_COUNT-1:0] stage3;
    logic [godr_pkg::PIN_COUNT-1:0] agree;
    logic [godr_pkg::PIN_COUNT-1:0] next_level;

    // only stage2 reads meta; the comparison starts at stage2
    assign agree = ~(stage2 ^ stage3);
    assign next_level = (agree & stage3) | (~agree & level_out);

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            meta <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level_out <= '0;
        end
        else
        begin
            meta <= pad_in;
            stage2 <= meta;
            stage3 <= stage2;
            level_out <= next_level;
        end
    end
endmodule // godr_pin_sync

// ### test/godr_port_asserts.sv
// godr_port_asserts: port-level timing checks of the open-drain gpio port
// assumes one mclk_in domain with a synchronous active-low reset
`timescale 1ns/1ns
module godr_port_asserts
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic protected_write_enable_in,
    input wire logic protected_write_disable_in,
    input wire logic pin_direction_wr_in,
    input wire logic [31:0] pin_direction_wdata_in,
    input wire logic pin_value_clear_wr_in,
    input wire logic [31:0] pin_value_clear_wdata_in,
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe_out,
    input wire logic [31:0] pin_output_value_out,
    input wire logic [31:0] pin_direction_out,
    input wire logic [31:0] open_drain_select_out,
    input wire logic protected_write_open_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic [31:0] push_pull = pin_direction_out & ~open_drain_select_out;
    sequence s_locked_wr; pin_direction_wr_in && !protected_write_open_out; endsequence
    property p_od; (pad_out & open_drain_select_out) == 32'h0; endproperty
    a_od: assert property (p_od) else $error("open-drain pin drove high");
    property p_on; (pad_oe_out & push_pull) == push_pull; endproperty
    a_on: assert property (p_on) else $error("output pin not driven");
    property p_off; (pad_oe_out & ~pin_direction_out) == 32'h0; endproperty
    a_off: assert property (p_off) else $error("input pin driven");
    property p_clr;
        pin_value_clear_wr_in |=> (pin_output_value_out & $past(pin_value_clear_wdata_in)) == 32'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("cleared bit still set");
    property p_lock; s_locked_wr |=> $stable(pin_direction_out); endproperty
    a_lock: assert property (p_lock) else $error("locked write taken");
    sequence s_unlock; protected_write_enable_in && !protected_write_disable_in; endsequence
    sequence s_open_wr; pin_direction_wr_in && protected_write_open_out; endsequence
    property p_unlock; s_unlock |=> protected_write_open_out; endproperty
    a_unlock: assert property (p_unlock) else $error("protection did not open");
    property p_relock; protected_write_disable_in |=> !protected_write_open_out; endproperty
    a_relock: assert property (p_relock) else $error("protection did not close");
    property p_take; s_open_wr |=> pin_direction_out == $past(pin_direction_wdata_in); endproperty
    a_take: assert property (p_take) else $error("open direction write lost");
endmodule // godr_port_asserts
bind godr_port godr_port_asserts u_godr_port_asserts (.*);

// ### test/godr_line_partner.sv
// godr_line_partner: pull-up plus another open-drain driver on each shared line
// assumes the port's pad drive and enable per pin
`timescale 1ns/1ns
module godr_line_partner
(
    input wire logic [31:0] drive_in,
    input wire logic [31:0] drive_oe_in,
    input wire logic [31:0] pull_low_in,
    output logic [31:0] line_out
);
    // the peer only sinks; a released line rises through the pull-up
    assign line_out = ~pull_low_in & (~drive_oe_in | drive_in);
endmodule // godr_line_partner

// ### test/godr_port_test.sv
// godr_port_test: table-driven bench for the open-drain gpio port
// assumes the partner line model and the bound checker
`timescale 1ns/1ns
module godr_port_test;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic pe = 1'b0, pd = 1'b0, pw = 1'b0, ow = 1'b0, dw = 1'b0, vw = 1'b0, cw = 1'b0, opn;
    logic [31:0] pv = 32'h0, ov = 32'h0, dv = 32'h0, vv = 32'h0, cv = 32'h0, low = 32'h0;
    logic [31:0] pad, oe, pue, lvl, val, dir, odr, pud, line;
    int failures = 0;
    int n_tests = 0;
    // rows: select, value, direction, expected enable, expected drive
    logic [31:0] t [3][5] = '{'{32'h0, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff},
        '{32'hffff_ffff, 32'h0000_ffff, 32'h00ff_00ff, 32'h00ff_0000, 32'h0},
        '{32'h0, 32'h0, 32'h0f0f_0f0f, 32'h0f0f_0f0f, 32'h0}};
    always #2 mclk_in = ~mclk_in;
    godr_port u_godr_port (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .protected_write_enable_in(pe), .protected_write_disable_in(pd),
        .pullup_disable_wr_in(pw), .pullup_disable_wdata_in(pv), .open_drain_select_wr_in(ow),
        .open_drain_select_wdata_in(ov), .pin_direction_wr_in(dw), .pin_direction_wdata_in(dv),
        .pin_output_value_wr_in(vw), .pin_output_value_wdata_in(vv), .pin_value_clear_wr_in(cw),
        .pin_value_clear_wdata_in(cv), .pad_in(line), .pad_out(pad), .pad_oe_out(oe),
        .pad_pullup_en_out(pue), .pin_level_out(lvl), .pin_output_value_out(val),
        .pin_direction_out(dir), .open_drain_select_out(odr), .pullup_disable_out(pud),
        .protected_write_open_out(opn));
    godr_line_partner u_godr_line_partner (.drive_in(pad), .drive_oe_in(oe), .pull_low_in(low),
        .line_out(line));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic final_report;
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        step(12);
        chk(pue, 32'hffff_ffff);
        chk(oe, 32'h0);
        rst_n_in = 1'b1;
        pe = 1'b1;
        step(1);
        pe = 1'b0;
        foreach (t[i])
        begin
            {ow, vw, dw} = 3'h7;
            {ov, vv, dv} = {t[i][0], t[i][1], t[i][2]};
            step(1);
            {ow, vw, dw} = 3'h0;
            chk(oe, t[i][3]);
            chk(pad, t[i][4]);
            chk(odr, t[i][0]);
        end
        // a peer sinks one released pin; the synchroniser needs up to four edges
        low = 32'h0000_0010;
        step(5);
        chk(lvl, 32'hf0f0_f0e0);
        {vw, cw, vv, cv} = {2'h3, 32'hffff_ffff, 32'h0000_00ff};
        step(1);
        {vw, cw} = 2'h0;
        chk(val, 32'hffff_ff00);
        pd = 1'b1;
        step(1);
        {pd, dw, pw, dv, pv} = {3'h3, 32'hffff_ffff, 32'hffff_ffff};
        step(1);
        {dw, pw} = 2'h0;
        chk(dir, 32'h0f0f_0f0f);
        chk(pud, 32'h0);
        // awkward cases: reset mid-run, coinciding strobes, then an accepted pull-up write
        rst_n_in = 1'b0;
        step(2);
        chk(val | dir | odr | pud | pad | oe | lvl, 32'h0);
        chk(pue, 32'hffff_ffff);
        chk({31'h0, opn}, 32'h0);
        {rst_n_in, pe, pd, dw, dv} = {4'hf, 32'hffff_ffff};
        step(1);
        {pd, dw} = 2'h0;
        chk({31'h0, opn}, 32'h0);
        chk(dir, 32'h0);
        step(1);
        {pe, pw, ow, pv, ov} = {3'h3, 32'h0000_00ff, 32'h0000_0003};
        chk({31'h0, opn}, 32'h1);
        step(1);
        {pw, ow} = 2'h0;
        chk(pud, 32'h0000_00ff);
        chk(pue, 32'hffff_ff00);
        chk(odr, 32'h0000_0003);
        final_report();
    end
endmodule // godr_port_test
